// ==== core/kdrm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "kdrm_map.svh"

// Key-driven record memory manager.
module kdrm_top #(
    parameter int N         = `KDRM_RECORDS,
    parameter int VW        = 24,
    parameter int HOLD_CYC  = `KDRM_HOLD_CYC,
    parameter int BLINK_CYC = `KDRM_BLINK_CYC
)(
    input  wire logic            clock,
    input  wire logic            arst_n,
    input  wire logic            key_mem,
    input  wire logic            key_save,
    input  wire logic            key_read,
    input  wire logic            key_clear,
    input  wire logic            key_clear_down,
    input  wire logic            key_up,
    input  wire logic            key_down,
    input  wire logic [VW-1:0]   live_src,
    input  wire logic [VW-1:0]   live_meas,
    input  wire logic            div_on,
    input  wire logic [7:0]      div_n,
    input  wire logic [7:0]      div_m,
    output logic                 mem_mode,
    output logic [6:0]           rec_no,
    output logic                 read_blink,
    output logic                 source_en_allow,
    output logic                 warn_overwrite,
    output logic                 warn_clear,
    output logic                 warn_clear_all,
    output logic [1:0]           show,
    output logic [VW-1:0]        disp_src,
    output logic [VW-1:0]        disp_meas
);
    localparam int AW = 6;

    typedef struct packed {
        kdrm_pkg::kdrm_state_t fsm;
        logic [6:0]            no;
        logic                  from_read;
        logic [31:0]           blink_cnt;
        logic                  blink;
        logic                  mem_mode;
        logic [6:0]            rec_no;
        logic                  read_blink;
        logic                  src_allow;
        logic                  w_ov;
        logic                  w_cl;
        logic                  w_all;
        logic [1:0]            show;
        logic [VW-1:0]         d_src;
        logic [VW-1:0]         d_meas;
    } kdrm_st_t;

    kdrm_st_t          st_q;
    kdrm_st_t          st_d;
    logic              hold_hit;
    logic [VW-1:0]     src_val;
    logic [VW+7:0]     prod;
    kdrm_store_if #(.VW(VW), .AW(AW)) sif ();

    // ****************************************************************
    // Helpers: record store and clear-key hold timer.
    // ****************************************************************
    kdrm_store #(.N(N), .VW(VW), .AW(AW)) u_store
    (
        .clock  (clock),
        .arst_n (arst_n),
        .s      (sif)
    );

    // Long hold only counts while the plain memory-mode selection is up.
    kdrm_hold #(.LIMIT(HOLD_CYC)) u_hold
    (
        .clock    (clock),
        .arst_n   (arst_n),
        .key_down (key_clear_down),
        .arm      (st_q.fsm == kdrm_pkg::KDRM_SELECT),
        .reached  (hold_hit)
    );

    // ****************************************************************
    // Source value to store, scaled when divided output is on.
    // ****************************************************************
    // A zero denominator keeps the plain setpoint.
    always_comb
    begin
        prod    = (VW+8)'(live_src) * (VW+8)'(div_n);
        src_val = live_src;
        if (div_on && div_m != 8'h00)
            src_val = VW'(prod / (VW+8)'(div_m));
    end

    // Store addressing is zero-based while record numbers start at one.
    assign sif.addr    = AW'(st_q.no - 7'h01);
    assign sif.wr_src  = src_val;
    assign sif.wr_meas = live_meas;

    // ****************************************************************
    // Key interpreter.
    // ****************************************************************
    always_comb
    begin
        st_d          = st_q;
        sif.wr        = 1'b0;
        sif.erase_one = 1'b0;
        sif.erase_all = 1'b0;
        unique case (st_q.fsm)
            kdrm_pkg::KDRM_IDLE:
            begin
                if (key_mem)
                begin
                    st_d.fsm = kdrm_pkg::KDRM_SELECT;
                    st_d.no  = sif.next_no;
                end
            end
            kdrm_pkg::KDRM_SELECT:
            begin
                if (key_mem)
                    st_d.fsm = kdrm_pkg::KDRM_IDLE;
                else if (hold_hit)
                    st_d.fsm = kdrm_pkg::KDRM_ALLWARN;
                else if (key_save)
                begin
                    st_d.from_read = 1'b0;
                    if (sif.rd_used)
                        st_d.fsm = kdrm_pkg::KDRM_OVWARN;
                    else
                    begin
                        sif.wr   = 1'b1;
                        st_d.fsm = kdrm_pkg::KDRM_IDLE;
                    end
                end
                else if (key_read)
                    st_d.fsm = kdrm_pkg::KDRM_READ;
                else if (key_clear)
                begin
                    st_d.from_read = 1'b0;
                    st_d.fsm       = kdrm_pkg::KDRM_CLWARN;
                end
            end
            kdrm_pkg::KDRM_READ:
            begin
                if (key_mem)
                    st_d.fsm = kdrm_pkg::KDRM_IDLE;
                else if (key_read)
                    st_d.fsm = kdrm_pkg::KDRM_SELECT;
                else if (key_save)
                begin
                    st_d.from_read = 1'b1;
                    if (sif.rd_used)
                        st_d.fsm = kdrm_pkg::KDRM_OVWARN;
                    else
                    begin
                        sif.wr   = 1'b1;
                        st_d.fsm = kdrm_pkg::KDRM_IDLE;
                    end
                end
                else if (key_clear)
                begin
                    st_d.from_read = 1'b1;
                    st_d.fsm       = kdrm_pkg::KDRM_CLWARN;
                end
            end
            kdrm_pkg::KDRM_OVWARN:
            begin
                if (key_mem)
                    st_d.fsm = kdrm_pkg::KDRM_SELECT;
                else if (key_save)
                begin
                    sif.wr   = 1'b1;
                    st_d.fsm = kdrm_pkg::KDRM_IDLE;
                end
            end
            kdrm_pkg::KDRM_CLWARN:
            begin
                if (key_mem)
                    st_d.fsm = kdrm_pkg::KDRM_SELECT;
                else if (key_clear)
                begin
                    sif.erase_one = 1'b1;
                    st_d.fsm      = st_q.from_read ? kdrm_pkg::KDRM_READ
                                                   : kdrm_pkg::KDRM_SELECT;
                end
            end
            kdrm_pkg::KDRM_ALLWARN:
            begin
                if (key_mem)
                    st_d.fsm = kdrm_pkg::KDRM_SELECT;
                else if (key_clear)
                begin
                    sif.erase_all = 1'b1;
                    st_d.fsm      = kdrm_pkg::KDRM_SELECT;
                end
            end
            default:
                st_d.fsm = kdrm_pkg::KDRM_IDLE;
        endcase

        // Record selection wraps between one and the top record.
        if (st_q.fsm == kdrm_pkg::KDRM_SELECT || st_q.fsm == kdrm_pkg::KDRM_READ)
        begin
            if (key_up && !key_down)
                st_d.no = (st_q.no >= 7'(N)) ? 7'h01 : st_q.no + 7'h01;
            else if (key_down && !key_up)
                st_d.no = (st_q.no <= 7'h01) ? 7'(N) : st_q.no - 7'h01;
        end

        // Blink timer free-runs only inside the read state.
        if (st_q.fsm == kdrm_pkg::KDRM_READ)
        begin
            if (st_q.blink_cnt >= 32'(BLINK_CYC - 1))
            begin
                st_d.blink_cnt = '0;
                st_d.blink     = ~st_q.blink;
            end
            else
                st_d.blink_cnt = st_q.blink_cnt + 32'h1;
        end
        else
        begin
            st_d.blink_cnt = '0;
            st_d.blink     = 1'b1;
        end

        // Registered outputs follow the state one cycle later.
        st_d.mem_mode   = (st_q.fsm != kdrm_pkg::KDRM_IDLE);
        st_d.rec_no     = st_q.no;
        st_d.read_blink = (st_q.fsm == kdrm_pkg::KDRM_READ) && st_q.blink;
        st_d.src_allow  = (st_q.fsm != kdrm_pkg::KDRM_READ);
        st_d.w_ov       = (st_q.fsm == kdrm_pkg::KDRM_OVWARN);
        st_d.w_cl       = (st_q.fsm == kdrm_pkg::KDRM_CLWARN);
        st_d.w_all      = (st_q.fsm == kdrm_pkg::KDRM_ALLWARN);
        if (st_q.fsm == kdrm_pkg::KDRM_READ)
        begin
            st_d.show   = sif.rd_used ? 2'(kdrm_pkg::KDRM_SHOW_VALUE)
                                      : 2'(kdrm_pkg::KDRM_SHOW_DASH);
            st_d.d_src  = sif.rd_used ? sif.rd_src : '0;
            st_d.d_meas = sif.rd_used ? sif.rd_meas : '0;
        end
        else
        begin
            st_d.show   = 2'(kdrm_pkg::KDRM_SHOW_NONE);
            st_d.d_src  = '0;
            st_d.d_meas = '0;
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q           <= '0;
            st_q.fsm       <= kdrm_pkg::KDRM_IDLE;
            st_q.no        <= `KDRM_FIRST_NO;
            st_q.src_allow <= 1'b1;
            st_q.blink     <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    assign mem_mode        = st_q.mem_mode;
    assign rec_no          = st_q.rec_no;
    assign read_blink      = st_q.read_blink;
    assign source_en_allow = st_q.src_allow;
    assign warn_overwrite  = st_q.w_ov;
    assign warn_clear      = st_q.w_cl;
    assign warn_clear_all  = st_q.w_all;
    assign show            = st_q.show;
    assign disp_src        = st_q.d_src;
    assign disp_meas       = st_q.d_meas;
endmodule

`default_nettype wire

// ==== core/kdrm_map.svh ====
// Operation
// - Hold up to fifty records, each a sourced value paired with a measured value.
// - Keep the source output disabled whenever stored records are being shown.
// - Entering memory mode offers the number after the highest occupied record.
// - Save stores displayed source and measure values, then returns to normal mode.
// - After a save above every other occupied record, re-entering memory mode offers the saved number plus one, at most 50.
// - Offered number follows the highest occupied record, ignoring lower gaps.
// - With divided output active, the stored source value is setpoint times n over m.
// - Number up and down keys move the selected record in memory mode.
// - Saving onto an occupied record warns first; a second save replaces it.
// - Memory key during the overwrite warning abandons the save, back to memory mode.
// - Memory key in memory mode before saving exits without storing anything.
// - Read enters the read state and blinks the read indication throughout it.
// - Read state shows the record's values, or a dash pattern when it is empty.
// - Memory key or read key leaves the read state.
// - Save from the read state follows the confirmed overwrite sequence.
// - Clear shows a warning with the record number; a second clear erases it.
// - Memory key during any clear warning aborts and returns to memory mode.
// - Holding clear five seconds in memory mode shows the global clear warning.
// - Clear during the global clear warning erases every stored record.
// - Single record clearing is also accepted while the record is being read.
`ifndef KDRM_MAP_SVH
`define KDRM_MAP_SVH

// ****************************************************************
// Sizes and timing.
// ****************************************************************
`define KDRM_RECORDS        50
`define KDRM_CLK_HZ         125000000
`define KDRM_HOLD_SEC       5
`define KDRM_HOLD_CYC       (`KDRM_HOLD_SEC * `KDRM_CLK_HZ)
`define KDRM_BLINK_CYC      62500000
`define KDRM_FIRST_NO       7'h01

`endif

// ==== core/kdrm_pkg.sv ====
package kdrm_pkg;

    // ****************************************************************
    // Types used by the manager alone, not by its helpers.
    // ****************************************************************
    typedef enum logic [2:0] {
        KDRM_IDLE   = 3'b000,
        KDRM_SELECT = 3'b001,
        KDRM_READ   = 3'b011,
        KDRM_OVWARN = 3'b010,
        KDRM_CLWARN = 3'b110,
        KDRM_ALLWARN = 3'b111
    } kdrm_state_t;

    typedef enum logic [1:0] {
        KDRM_SHOW_NONE  = 2'h0,
        KDRM_SHOW_DASH  = 2'h1,
        KDRM_SHOW_VALUE = 2'h2
    } kdrm_show_t;

endpackage

// ==== core/kdrm_store_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Write, erase and lookup path between the manager and the record store.
interface kdrm_store_if #(
    parameter int VW = 24,
    parameter int AW = 6
);
    logic          wr;
    logic          erase_one;
    logic          erase_all;
    logic [AW-1:0] addr;
    logic [VW-1:0] wr_src;
    logic [VW-1:0] wr_meas;
    logic [VW-1:0] rd_src;
    logic [VW-1:0] rd_meas;
    logic          rd_used;
    logic [AW:0]   next_no;

    modport mgr
    (
        output wr, erase_one, erase_all, addr, wr_src, wr_meas,
        input  rd_src, rd_meas, rd_used, next_no
    );
    modport store
    (
        input  wr, erase_one, erase_all, addr, wr_src, wr_meas,
        output rd_src, rd_meas, rd_used, next_no
    );
endinterface

`default_nettype wire

// ==== core/kdrm_store.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "kdrm_map.svh"

// Record array with per-entry occupancy and next-number tracking.
module kdrm_store #(
    parameter int N  = `KDRM_RECORDS,
    parameter int VW = 24,
    parameter int AW = 6
)(
    input  wire logic   clock,
    input  wire logic   arst_n,
    kdrm_store_if.store s
);
    typedef struct packed {
        logic [N-1:0] used;
    } kdrm_sst_t;

    logic [VW-1:0] src_mem  [N];
    logic [VW-1:0] meas_mem [N];
    kdrm_sst_t     st_q;
    kdrm_sst_t     st_d;
    logic [AW:0]   hi;

    // ****************************************************************
    // Occupancy flags; erase of one entry or of all.
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        if (s.erase_all)
            st_d.used = '0;
        else if (s.erase_one)
            st_d.used[s.addr] = 1'b0;
        else if (s.wr)
            st_d.used[s.addr] = 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // Data words need no reset; the occupancy flag guards every read.
    always_ff @(posedge clock)
    begin
        if (s.wr)
        begin
            src_mem[s.addr]  <= s.wr_src;
            meas_mem[s.addr] <= s.wr_meas;
        end
    end

    // Highest occupied index decides the next offered number, gaps ignored.
    always_comb
    begin
        hi = '0;
        for (int i = 0; i < N; i++)
            if (st_q.used[i])
                hi = (AW+1)'(i + 1);
    end

    assign s.next_no = (hi >= (AW+1)'(N)) ? (AW+1)'(N) : hi + (AW+1)'(1);
    assign s.rd_src  = src_mem[s.addr];
    assign s.rd_meas = meas_mem[s.addr];
    assign s.rd_used = st_q.used[s.addr];
endmodule

`default_nettype wire

// ==== core/kdrm_hold.sv ====
`timescale 1ns/1ps
`default_nettype none

// Counts how long a key stays down; fires once when the limit is reached.
module kdrm_hold #(
    parameter int LIMIT = 625000000
)(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic key_down,
    input  wire logic arm,
    output logic      reached
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        done;
    } kdrm_hst_t;

    kdrm_hst_t st_q;
    kdrm_hst_t st_d;

    // ****************************************************************
    // Hold timer.
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        if (!key_down || !arm)
        begin
            st_d.cnt  = '0;
            st_d.done = 1'b0;
        end
        else if (!st_q.done)
        begin
            if (st_q.cnt >= 32'(LIMIT - 1))
                st_d.done = 1'b1;
            else
                st_d.cnt = st_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // Pulse only on the cycle the limit is first met.
    assign reached = st_d.done && !st_q.done;
endmodule

`default_nettype wire

// ==== testbench/kdrm_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port checker for the record manager.
// ****************************************
module kdrm_properties #(
    parameter int N         = 50,
    parameter int BLINK_CYC = 4
)(
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       key_mem,
    input wire logic       key_save,
    input wire logic       key_read,
    input wire logic       key_clear,
    input wire logic       mem_mode,
    input wire logic [6:0] rec_no,
    input wire logic       read_blink,
    input wire logic       source_en_allow,
    input wire logic       warn_overwrite,
    input wire logic       warn_clear,
    input wire logic       warn_clear_all,
    input wire logic [1:0] show
);
    logic        blink_q;
    logic [31:0] still_q;
    logic [31:0] still_d;
    logic        any_warn;
    logic        sel;

    // Decoded selection state, seen only through the outputs.
    assign any_warn = warn_overwrite || warn_clear || warn_clear_all;
    assign sel      = mem_mode && source_en_allow && !any_warn;

    // Counts cycles in the read state without a blink edge.
    always_comb
    begin
        still_d = (source_en_allow || read_blink != blink_q) ? 32'h0 : still_q + 32'h1;
    end

    // Helper registers; a stuck blink makes the count run away.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            blink_q <= 1'b0;
            still_q <= 32'h0;
        end
        else
        begin
            blink_q <= read_blink;
            still_q <= still_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    read_src_off_a: assert property (show != 2'h0 |-> !source_en_allow)
        else $error("record shown while source allowed");
    idle_quiet_a: assert property (!mem_mode |-> source_en_allow && !read_blink)
        else $error("read indication outside memory mode");
    blink_runs_a: assert property (still_q < BLINK_CYC + 2)
        else $error("read indication stopped blinking");
    recno_range_a: assert property (mem_mode |-> rec_no >= 7'h01 && rec_no <= N)
        else $error("record number out of range");
    ovw_abort_a: assert property (key_mem ##1 warn_overwrite |-> ##1 mem_mode && !warn_overwrite)
        else $error("overwrite abort failed");
    clr_abort_a: assert property (key_mem ##1 (warn_clear || warn_clear_all)
        |-> ##1 mem_mode && !warn_clear && !warn_clear_all) else $error("clear abort failed");
    read_exit_a: assert property (key_mem ##1 !source_en_allow |-> ##1 !mem_mode && source_en_allow)
        else $error("read state not left");
    sel_exit_a: assert property (key_mem ##1 sel |-> ##1 !mem_mode)
        else $error("memory mode not left");
    save_acts_a: assert property (key_save && !key_mem ##1 sel |-> ##1 !mem_mode || warn_overwrite)
        else $error("save neither stored nor warned");
    clr_warn_a: assert property (key_clear && !key_mem && !key_save && !key_read
        ##1 mem_mode && !any_warn |-> ##1 warn_clear) else $error("clear warning missing");

    // Main scenarios reached.
    cover property (warn_overwrite && key_save);
    cover property (warn_clear_all && key_clear);
    cover property (!source_en_allow && show == 2'h1);
endmodule

bind kdrm_top kdrm_properties #(.N(N), .BLINK_CYC(BLINK_CYC)) chk_u (
    .clock(clock), .arst_n(arst_n), .key_mem(key_mem), .key_save(key_save),
    .key_read(key_read), .key_clear(key_clear), .mem_mode(mem_mode), .rec_no(rec_no),
    .read_blink(read_blink), .source_en_allow(source_en_allow),
    .warn_overwrite(warn_overwrite), .warn_clear(warn_clear),
    .warn_clear_all(warn_clear_all), .show(show)
);

`default_nettype wire

// ==== testbench/kdrm_panel.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Operator model: front-panel keys and live values.
// ****************************************
module kdrm_panel #(
    parameter int VW = 24
)(
    input  wire logic     clock,
    output logic          key_mem,
    output logic          key_save,
    output logic          key_read,
    output logic          key_clear,
    output logic          key_clear_down,
    output logic          key_up,
    output logic          key_down,
    output logic [VW-1:0] live_src,
    output logic [VW-1:0] live_meas,
    output logic          div_on,
    output logic [7:0]    div_n,
    output logic [7:0]    div_m
);
    logic [5:0] keys;

    // One bit per momentary key, in press-code order.
    assign {key_down, key_up, key_clear, key_read, key_save, key_mem} = keys;

    // Idle panel at time zero.
    initial
    begin
        keys = 6'h00;
        key_clear_down = 1'b0;
        live_src = '0;
        live_meas = '0;
        div_on = 1'b0;
        div_n = 8'h01;
        div_m = 8'h01;
    end

    // One-cycle press, then room for the two-edge answer.
    task automatic press(input int k);
        @(negedge clock);
        keys[k] = 1'b1;
        @(negedge clock);
        keys = 6'h00;
        repeat (2) @(negedge clock);
    endtask

    // Holds the clear key down without a press pulse.
    task automatic hold(input int n);
        @(negedge clock);
        key_clear_down = 1'b1;
        repeat (n) @(negedge clock);
        key_clear_down = 1'b0;
        repeat (2) @(negedge clock);
    endtask

    // Values the display shows at the moment of a save.
    task automatic set_live(input logic [VW-1:0] s, input logic [VW-1:0] m,
                            input logic d, input logic [7:0] n, input logic [7:0] q);
        @(negedge clock);
        live_src = s;
        live_meas = m;
        div_on = d;
        div_n = n;
        div_m = q;
    endtask
endmodule

`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) \
    begin \
        samples_checked++; \
        if ((a) !== (e)) \
        begin \
            fail_count++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
        end \
    end

// ****************************************
// Bench for the record manager.
// ****************************************
module tb_top;
    localparam int KM = 0;
    localparam int KS = 1;
    localparam int KR = 2;
    localparam int KC = 3;
    localparam int KU = 4;
    localparam int KD = 5;

    logic        clock;
    logic        arst_n;
    wire logic   k_mem, k_save, k_read, k_clr, k_clr_dn, k_up, k_dn, div_on;
    wire logic [23:0] live_src, live_meas;
    wire logic [7:0]  div_n, div_m;
    logic        mem_mode, read_blink, src_ok, w_ovw, w_clr, w_all;
    logic [6:0]  rec_no;
    logic [1:0]  show;
    logic [23:0] disp_src, disp_meas;
    int          fail_count;
    int          samples_checked;
    int          cycles;

    kdrm_top #(.HOLD_CYC(20), .BLINK_CYC(4)) dut_u (
        .clock(clock), .arst_n(arst_n), .key_mem(k_mem), .key_save(k_save),
        .key_read(k_read), .key_clear(k_clr), .key_clear_down(k_clr_dn),
        .key_up(k_up), .key_down(k_dn), .live_src(live_src), .live_meas(live_meas),
        .div_on(div_on), .div_n(div_n), .div_m(div_m), .mem_mode(mem_mode),
        .rec_no(rec_no), .read_blink(read_blink), .source_en_allow(src_ok),
        .warn_overwrite(w_ovw), .warn_clear(w_clr), .warn_clear_all(w_all),
        .show(show), .disp_src(disp_src), .disp_meas(disp_meas)
    );

    kdrm_panel #(.VW(24)) panel_u (
        .clock(clock), .key_mem(k_mem), .key_save(k_save), .key_read(k_read),
        .key_clear(k_clr), .key_clear_down(k_clr_dn), .key_up(k_up), .key_down(k_dn),
        .live_src(live_src), .live_meas(live_meas), .div_on(div_on),
        .div_n(div_n), .div_m(div_m)
    );

    // Free-running 125 MHz clock.
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Hang guard; the tests need under a thousand cycles.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Sequential saves, the divided source value and a plain exit.
    task automatic t_save;
        panel_u.set_live(24'h000123, 24'h000456, 1'b0, 8'h03, 8'h04);
        panel_u.press(KM);
        `CHK(rec_no, 7'h01)
        panel_u.press(KS);
        `CHK(mem_mode, 1'b0)
        panel_u.press(KM);
        `CHK(rec_no, 7'h02)
        panel_u.set_live(24'h000100, 24'h000200, 1'b1, 8'h03, 8'h04);
        panel_u.press(KS);
        panel_u.press(KM);
        `CHK(rec_no, 7'h03)
        panel_u.press(KM);
        `CHK(mem_mode, 1'b0)
        $display("t_save done");
    endtask

    // Reading an empty and two full records, blink, both exits.
    task automatic t_read;
        logic b;
        panel_u.press(KM);
        panel_u.press(KR);
        `CHK(src_ok, 1'b0)
        `CHK(show, 2'h1)
        panel_u.press(KD);
        `CHK(disp_src, 24'h0000c0)
        `CHK(disp_meas, 24'h000200)
        panel_u.press(KD);
        `CHK(rec_no, 7'h01)
        `CHK(disp_src, 24'h000123)
        b = read_blink;
        repeat (4) @(negedge clock);
        `CHK(read_blink, ~b)
        panel_u.press(KR);
        `CHK(src_ok, 1'b1)
        panel_u.press(KR);
        panel_u.press(KM);
        `CHK(mem_mode, 1'b0)
        $display("t_read done");
    endtask

    // Overwrite warning, abort, confirm, and save from the read state.
    task automatic t_over;
        panel_u.set_live(24'h000777, 24'h000888, 1'b0, 8'h01, 8'h01);
        panel_u.press(KM);
        panel_u.press(KD);
        panel_u.press(KD);
        panel_u.press(KS);
        `CHK(w_ovw, 1'b1)
        panel_u.press(KM);
        `CHK({w_ovw, mem_mode}, 2'b01)
        panel_u.press(KS);
        panel_u.press(KS);
        `CHK(mem_mode, 1'b0)
        panel_u.press(KM);
        panel_u.press(KD);
        panel_u.press(KD);
        panel_u.press(KR);
        `CHK(disp_src, 24'h000777)
        panel_u.press(KS);
        `CHK(w_ovw, 1'b1)
        panel_u.press(KS);
        `CHK(mem_mode, 1'b0)
        $display("t_over done");
    endtask

    // Save past a gap, single clears from select and from read.
    task automatic t_gap;
        panel_u.press(KM);
        panel_u.press(KU);
        panel_u.press(KU);
        panel_u.press(KS);
        panel_u.press(KM);
        `CHK(rec_no, 7'h06)
        panel_u.press(KD);
        panel_u.press(KC);
        `CHK(w_clr, 1'b1)
        panel_u.press(KM);
        `CHK({w_clr, mem_mode}, 2'b01)
        panel_u.press(KC);
        panel_u.press(KC);
        panel_u.press(KM);
        panel_u.press(KM);
        `CHK(rec_no, 7'h03)
        panel_u.press(KD);
        panel_u.press(KR);
        panel_u.press(KC);
        `CHK(w_clr, 1'b1)
        panel_u.press(KC);
        `CHK(show, 2'h1)
        panel_u.press(KM);
        $display("t_gap done");
    endtask

    // Long hold, its abort, global erase and the number wrap.
    task automatic t_all;
        panel_u.press(KM);
        panel_u.hold(25);
        `CHK(w_all, 1'b1)
        panel_u.press(KM);
        `CHK({w_all, mem_mode}, 2'b01)
        panel_u.hold(25);
        panel_u.press(KC);
        panel_u.press(KM);
        panel_u.press(KM);
        `CHK(rec_no, 7'h01)
        panel_u.press(KD);
        `CHK(rec_no, 7'h32)
        panel_u.press(KR);
        `CHK(show, 2'h1)
        panel_u.press(KM);
        $display("t_all done");
    endtask

    // Reset, then every scenario in turn.
    initial
    begin
        arst_n = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        `CHK({mem_mode, src_ok}, 2'b01)
        t_save();
        t_read();
        t_over();
        t_gap();
        t_all();
        close_out();
    end
endmodule

`default_nettype wire
